// [inc/tah_pkg.sv]
// Constants and types of the approach sequencer.
package tah_pkg;

   // ==========================================================================
   // Register byte offsets.
   localparam logic [7:0] TAH_CTRL_OFS   = 8'h00;
   localparam logic [7:0] TAH_APR_OFS    = 8'h04;
   localparam logic [7:0] TAH_CRS_OFS    = 8'h08;
   localparam logic [7:0] TAH_PATH_OFS   = 8'h0C;
   localparam logic [7:0] TAH_HSK_OFS    = 8'h10;
   localparam logic [7:0] TAH_TMO_OFS    = 8'h14;
   localparam logic [7:0] TAH_STAT_OFS   = 8'h18;
   localparam logic [7:0] TAH_POINT_OFS  = 8'h1C;

   // ==========================================================================
   // Control register command bits.
   localparam int TAH_CTRL_START_BIT   = 0;
   localparam int TAH_CTRL_STOP_BIT    = 1;
   localparam int TAH_CTRL_ADJ_BIT     = 2;
   localparam int TAH_CTRL_PATH_BIT    = 3;
   localparam int TAH_CTRL_PROCEED_BIT = 4;
   localparam int TAH_CTRL_FBEN_BIT    = 5;

   // Reset values.
   localparam logic [31:0] TAH_APR_RST  = 32'h0000_0001;
   localparam logic [31:0] TAH_CRS_RST  = 32'h0019_00C2;
   localparam logic [31:0] TAH_PATH_RST = 32'h0000_0004;
   localparam logic [31:0] TAH_HSK_RST  = 32'h0000_0005;
   localparam logic [31:0] TAH_TMO_RST  = 32'h0000_0000;

   // ==========================================================================
   // Millisecond tick timing.
   localparam int TAH_CLK_HZ      = 25_000_000;
   localparam int TAH_TICK_US     = 1000;
   localparam int TAH_TICK_CYC    = TAH_CLK_HZ / 1_000_000 * TAH_TICK_US;
   localparam int TAH_SER_CYC     = 8;

   // Coarse controller interface selections.
   localparam logic [1:0] TAH_DEV_SERIAL = 2'h0;
   localparam logic [1:0] TAH_DEV_TTL    = 2'h1;
   localparam logic [1:0] TAH_DEV_LVTTL  = 2'h2;
   localparam logic [1:0] TAH_DEV_CABLE  = 2'h3;

   // Serial link command codes.
   localparam logic [3:0] TAH_CMD_STEP   = 4'h1;
   localparam logic [3:0] TAH_CMD_EXT    = 4'h2;
   localparam logic [3:0] TAH_CMD_GND    = 4'h3;
   localparam logic [3:0] TAH_CMD_STEPMD = 4'h4;

   // Approach configuration fields.
   typedef struct packed {
      logic [7:0]  speed;
      logic [7:0]  steps;
      logic [7:0]  delay_ms;
      logic [2:0]  spare;
      logic        no_coarse;
      logic        single_z;
      logic        gnd_apr;
      logic        target_loop;
      logic        mode_ramp;
   } tah_apr_cfg_t;

   // Coarse device configuration fields.
   typedef struct packed {
      logic [7:0]  spare;
      logic [7:0]  hold_ms;
      logic [7:0]  spare2;
      logic [1:0]  axis;
      logic        dir_bwd;
      logic        pol_low;
      logic        spare3;
      logic        spare4;
      logic [1:0]  device;
   } tah_crs_cfg_t;

   // Coarse command word sent over serial or cable link.
   typedef struct packed {
      logic [3:0]  cmd;
      logic [1:0]  axis;
      logic        dir_bwd;
      logic        spare;
   } tah_crs_word_t;

   // Main sequencer states.
   typedef enum logic [10:0] {
      TAH_IDLE   = 11'b000_0000_0001,
      TAH_RAMP   = 11'b000_0000_0010,
      TAH_RETR   = 11'b000_0000_0100,
      TAH_STEP   = 11'b000_0000_1000,
      TAH_SETTLE = 11'b000_0001_0000,
      TAH_ADJ    = 11'b000_0010_0000,
      TAH_MOVE   = 11'b000_0100_0000,
      TAH_TRIG   = 11'b000_1000_0000,
      TAH_WACK   = 11'b001_0000_0000,
      TAH_MANUAL = 11'b010_0000_0000,
      TAH_DWELL  = 11'b100_0000_0000
   } tah_state_t;

endpackage

// [design/tah_seq.sv]
// Approach and path-mode handshake sequencer with AHB-Lite register slave.
//
// Functional notes
// [RULE_01] Configured step count after each failed ramp.
// [RULE_02] Loop or ramp approach mode; speed used in ramp only.
// [RULE_03] Stop condition: feedback on or retract, per target mode.
// [RULE_04] Approach-active status high while approach runs.
// [RULE_05] Start command begins the approach.
// [RULE_06] Adjust: feedback off, one coarse step, feedback on.
// [RULE_07] Feedback off at adjust stays off.
// [RULE_08] No-coarse option: approach without coarse steps.
// [RULE_09] Shared z piezo: external drive mode during approach.
// [RULE_10] Ground option: grounded while z scanner expands.
// [RULE_11] Configurable coarse axis, default axis 3.
// [RULE_12] Configurable coarse direction, forward by default.
// [RULE_13] Serial, TTL pulse, LVTTL pulse or cable interface.
// [RULE_14] Path mode visits points in order, acting at each.
// [RULE_15] Manual handshake waits for proceed at each point.
// [RULE_16] Trigger pulse only once the tip reached the point.
// [RULE_17] Acknowledge moves on or repeats the handshake.
// [RULE_18] Instrument measures on trigger, then acknowledges.
// [RULE_19] No acknowledge: fixed wait at each point.
// [RULE_20] Configurable handshake cycles per point.
// [RULE_21] Timeout zero disables the acknowledge timeout.
// [RULE_22] Acknowledge on falling or rising edge.
// [RULE_23] Waiting-for-acknowledge indication while waiting.
// [RULE_24] Pulse trigger polarity and hold time configurable.
module tah_seq
   import tah_pkg::*;
#(
   parameter int PTR_W = 8
) (
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   input  wire logic        stop_cond,
   input  wire logic        z_at_max,
   input  wire logic        z_at_home,
   input  wire logic        pos_reached,
   input  wire logic        ack_in,
   output logic             z_ramp_en,
   output logic             z_ramp_loop,
   output logic [7:0]       z_ramp_speed,
   output logic             z_retract,
   output logic             fb_en,
   output logic             approach_active,
   output logic             crs_ext_mode,
   output logic             crs_gnd_mode,
   output logic             aux_analog_out_2,
   output logic             aux_lv_level,
   output logic             crs_ser_valid,
   output logic [7:0]       crs_ser_data,
   output logic             dedicated_cable_link,
   output logic             path_move,
   output logic [PTR_W-1:0] path_point,
   output logic             trig_out,
   output logic             wait_ack
);

   // ==========================================================================
   // Elaboration check.
   if (PTR_W < 1 || PTR_W > 16) begin : g_chk
      $error("PTR_W out of range");
   end

   // ==========================================================================
   // Registers and state.
   tah_apr_cfg_t      apr_r;
   tah_crs_cfg_t      crs_r;
   logic [31:0]       path_r;
   logic [31:0]       hsk_r;
   logic [15:0]       tmo_r;
   tah_state_t        st_r;
   logic              cmd_start, cmd_stop, cmd_adj, cmd_path, cmd_proc, cmd_fb_on, cmd_fb_off;
   logic              wr_pend_r;
   logic [7:0]        addr_r;
   logic [15:0]       tick_cnt_r;
   logic              tick;
   logic [15:0]       ms_cnt_r;
   logic [7:0]        step_cnt_r;
   logic [7:0]        hs_cnt_r;
   logic              adj_fb_r;
   logic              step_go, step_busy;
   logic [15:0]       pulse_cnt_r;
   logic              ack_d_r;
   logic              ack_edge;
   logic              proceed_r;
   logic [PTR_W-1:0]  npts;

   // Path config: [PTR_W-1:0] point count, bit 16 manual, 17 external, 18 fixed wait,
   // bit 19 rising edge. Handshake: [7:0] count, [23:8] pulse ms, [31:24] dwell ms.
   assign npts = path_r[PTR_W-1:0];

   // Register read decode.
   function automatic logic [31:0] rd_mux(input logic [7:0] a);
      unique case (a)
         TAH_APR_OFS:   rd_mux = apr_r;
         TAH_CRS_OFS:   rd_mux = crs_r;
         TAH_PATH_OFS:  rd_mux = path_r;
         TAH_HSK_OFS:   rd_mux = hsk_r;
         TAH_TMO_OFS:   rd_mux = {16'h0000, tmo_r};
         TAH_STAT_OFS:  rd_mux = {21'h000000, st_r};
         TAH_POINT_OFS: rd_mux = {{(32-PTR_W){1'b0}}, path_point};
         default:       rd_mux = 32'h0000_0000;
      endcase
   endfunction

   // ==========================================================================
   // AHB-Lite slave: zero wait states, always OKAY, unmapped reads as zero.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         wr_pend_r <= 1'b0;
         addr_r    <= 8'h00;
         hrdata    <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         wr_pend_r <= 1'b0;
         if (hsel && hready && htrans[1]) begin
            addr_r    <= haddr[7:0];
            wr_pend_r <= hwrite;
            hrdata    <= hwrite ? 32'h0000_0000 : rd_mux({haddr[7:2], 2'b00});
         end
      end
   end

   // Write data strobes for commands.
   always_comb begin
      cmd_start  = 1'b0;
      cmd_stop   = 1'b0;
      cmd_adj    = 1'b0;
      cmd_path   = 1'b0;
      cmd_proc   = 1'b0;
      cmd_fb_on  = 1'b0;
      cmd_fb_off = 1'b0;
      if (wr_pend_r && addr_r == TAH_CTRL_OFS) begin
         cmd_start  = hwdata[TAH_CTRL_START_BIT];   // RULE_05
         cmd_stop   = hwdata[TAH_CTRL_STOP_BIT];
         cmd_adj    = hwdata[TAH_CTRL_ADJ_BIT];
         cmd_path   = hwdata[TAH_CTRL_PATH_BIT];
         cmd_proc   = hwdata[TAH_CTRL_PROCEED_BIT];
         cmd_fb_on  = hwdata[TAH_CTRL_FBEN_BIT];
         cmd_fb_off = !hwdata[TAH_CTRL_FBEN_BIT] && hwdata[7];
      end
   end

   // Configuration register writes.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         apr_r  <= TAH_APR_RST;
         crs_r  <= TAH_CRS_RST;
         path_r <= TAH_PATH_RST;
         hsk_r  <= TAH_HSK_RST;
         tmo_r  <= TAH_TMO_RST[15:0];
      end else if (wr_pend_r) begin
         unique case (addr_r)
            TAH_APR_OFS:  apr_r  <= hwdata;
            TAH_CRS_OFS:  crs_r  <= hwdata;
            TAH_PATH_OFS: path_r <= hwdata;
            TAH_HSK_OFS:  hsk_r  <= hwdata;
            TAH_TMO_OFS:  tmo_r  <= hwdata[15:0];
            default:      ;
         endcase
      end
   end

   // ==========================================================================
   // Millisecond tick divider.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         tick_cnt_r <= 16'h0000;
         tick       <= 1'b0;
      end else begin
         tick <= (tick_cnt_r == 16'(TAH_TICK_CYC - 1));
         if (tick_cnt_r == 16'(TAH_TICK_CYC - 1)) begin
            tick_cnt_r <= 16'h0000;
         end else begin
            tick_cnt_r <= tick_cnt_r + 16'h0001;
         end
      end
   end

   // ==========================================================================
   // Coarse step driver.
   assign step_busy = (pulse_cnt_r != 16'h0000);

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         pulse_cnt_r          <= 16'h0000;
         aux_analog_out_2     <= 1'b0;
         aux_lv_level         <= 1'b0;
         crs_ser_valid        <= 1'b0;
         crs_ser_data         <= 8'h00;
         dedicated_cable_link <= 1'b0;
      end else begin
         crs_ser_valid        <= 1'b0;
         dedicated_cable_link <= 1'b0;
         if (step_go) begin
            unique case (crs_r.device)   // RULE_13
               TAH_DEV_TTL, TAH_DEV_LVTTL: begin
                  pulse_cnt_r      <= {8'h00, crs_r.hold_ms};   // RULE_24
                  aux_analog_out_2 <= !crs_r.pol_low;   // RULE_24
                  aux_lv_level     <= (crs_r.device == TAH_DEV_LVTTL);
               end
               default: begin
                  pulse_cnt_r   <= 16'(TAH_SER_CYC);
                  crs_ser_valid <= (crs_r.device == TAH_DEV_SERIAL);
                  dedicated_cable_link <= (crs_r.device == TAH_DEV_CABLE);
                  crs_ser_data  <= {TAH_CMD_STEP, crs_r.axis, crs_r.dir_bwd, 1'b0};   // RULE_11
               end
            endcase
         end else if (step_busy) begin
            if (crs_r.device == TAH_DEV_TTL || crs_r.device == TAH_DEV_LVTTL) begin
               if (tick) begin
                  pulse_cnt_r <= pulse_cnt_r - 16'h0001;
               end
            end else begin
               pulse_cnt_r <= pulse_cnt_r - 16'h0001;
            end
         end else begin
            aux_analog_out_2 <= crs_r.pol_low;   // RULE_24
         end
      end
   end

   // ==========================================================================
   // Acknowledge edge detector and manual proceed latch.
   assign ack_edge = path_r[19] ? (ack_in && !ack_d_r) : (!ack_in && ack_d_r);   // RULE_22

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         ack_d_r   <= 1'b0;
         proceed_r <= 1'b0;
      end else begin
         ack_d_r <= ack_in;
         if (cmd_proc) begin
            proceed_r <= 1'b1;
         end else if (st_r == TAH_MANUAL) begin
            proceed_r <= 1'b0;
         end
      end
   end

   // ==========================================================================
   // Main sequencer.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         st_r        <= TAH_IDLE;
         step_cnt_r  <= 8'h00;
         hs_cnt_r    <= 8'h00;
         ms_cnt_r    <= 16'h0000;
         adj_fb_r    <= 1'b0;
         step_go     <= 1'b0;
         fb_en       <= 1'b0;
         z_retract   <= 1'b0;
         path_point  <= '0;
         path_move   <= 1'b0;
         trig_out    <= 1'b0;
      end else begin
         step_go <= 1'b0;
         if (cmd_fb_on && st_r == TAH_IDLE) begin
            fb_en <= 1'b1;
         end else if (cmd_fb_off && st_r == TAH_IDLE) begin
            fb_en <= 1'b0;
         end
         if (tick && ms_cnt_r != 16'h0000) begin
            ms_cnt_r <= ms_cnt_r - 16'h0001;
         end
         unique case (st_r)
            TAH_IDLE: begin
               path_move <= 1'b0;
               if (cmd_start) begin
                  st_r      <= TAH_RAMP;   // RULE_05
                  fb_en     <= 1'b0;
                  z_retract <= 1'b0;
               end else if (cmd_adj) begin
                  adj_fb_r <= fb_en;
                  fb_en    <= 1'b0;   // RULE_06
                  step_go  <= 1'b1;   // RULE_06
                  st_r     <= TAH_ADJ;
               end else if (cmd_path && npts != '0) begin
                  path_point <= '0;
                  path_move  <= 1'b1;
                  st_r       <= TAH_MOVE;
               end
            end
            TAH_RAMP: begin
               if (cmd_stop) begin
                  st_r <= TAH_IDLE;
               end else if (stop_cond) begin
                  fb_en     <= apr_r.target_loop;   // RULE_03
                  z_retract <= !apr_r.target_loop;   // RULE_03
                  st_r      <= TAH_IDLE;
               end else if (z_at_max) begin
                  z_retract <= 1'b1;
                  st_r      <= TAH_RETR;
               end
            end
            TAH_RETR: begin
               if (cmd_stop) begin
                  st_r <= TAH_IDLE;
               end else if (z_at_home) begin
                  z_retract  <= 1'b0;
                  step_cnt_r <= apr_r.steps;   // RULE_01
                  ms_cnt_r   <= {8'h00, apr_r.delay_ms};
                  st_r       <= (apr_r.no_coarse || apr_r.steps == 8'h00) ?
                                TAH_SETTLE : TAH_STEP;   // RULE_08
               end
            end
            TAH_STEP: begin
               if (cmd_stop) begin
                  st_r <= TAH_IDLE;
               end else if (!step_busy && !step_go) begin
                  if (step_cnt_r == 8'h00) begin
                     ms_cnt_r <= {8'h00, apr_r.delay_ms};
                     st_r     <= TAH_SETTLE;
                  end else begin
                     step_go    <= 1'b1;   // RULE_01
                     step_cnt_r <= step_cnt_r - 8'h01;
                  end
               end
            end
            TAH_SETTLE: begin
               if (cmd_stop) begin
                  st_r <= TAH_IDLE;
               end else if (ms_cnt_r == 16'h0000) begin
                  st_r <= TAH_RAMP;
               end
            end
            TAH_ADJ: begin
               if (!step_busy && !step_go) begin
                  fb_en <= adj_fb_r;   // RULE_07
                  st_r  <= TAH_IDLE;
               end
            end
            TAH_MOVE: begin
               path_move <= 1'b0;
               if (pos_reached && !path_move) begin   // RULE_16
                  hs_cnt_r <= hsk_r[7:0];
                  if (path_r[16]) begin
                     st_r <= TAH_MANUAL;   // RULE_14
                  end else if (path_r[17] && hsk_r[7:0] != 8'h00) begin
                     st_r <= TAH_TRIG;
                  end else begin
                     ms_cnt_r <= {8'h00, hsk_r[31:24]};
                     st_r     <= TAH_DWELL;
                  end
               end
            end
            TAH_MANUAL: begin
               if (proceed_r) begin   // RULE_15
                  ms_cnt_r <= {8'h00, hsk_r[31:24]};
                  st_r <= (path_r[17] && hsk_r[7:0] != 8'h00) ? TAH_TRIG : TAH_DWELL;
               end
            end
            TAH_TRIG: begin
               trig_out <= 1'b1;   // RULE_16
               ms_cnt_r <= hsk_r[23:8];
               hs_cnt_r <= hs_cnt_r - 8'h01;   // RULE_20
               st_r     <= TAH_WACK;
            end
            TAH_WACK: begin
               if (trig_out) begin
                  if (ms_cnt_r == 16'h0000) begin
                     trig_out <= 1'b0;
                     ms_cnt_r <= tmo_r;   // RULE_21
                  end
               end else if (ack_edge || (ms_cnt_r == 16'h0000 &&
                            (path_r[18] || tmo_r != 16'h0000))) begin   // RULE_17
                  st_r     <= (hs_cnt_r != 8'h00) ? TAH_TRIG : TAH_DWELL;   // RULE_20
                  ms_cnt_r <= {8'h00, hsk_r[31:24]};
               end
            end
            TAH_DWELL: begin
               if (ms_cnt_r == 16'h0000) begin   // RULE_19
                  if (path_point == npts - 1'b1) begin
                     st_r <= TAH_IDLE;
                  end else begin
                     path_point <= path_point + 1'b1;   // RULE_14
                     path_move  <= 1'b1;
                     st_r       <= TAH_MOVE;
                  end
               end
            end
            default: st_r <= TAH_IDLE;
         endcase
      end
   end

   // ==========================================================================
   // Approach and mode outputs.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         approach_active <= 1'b0;
         z_ramp_en       <= 1'b0;
         z_ramp_loop     <= 1'b0;
         z_ramp_speed    <= 8'h00;
         crs_ext_mode    <= 1'b0;
         crs_gnd_mode    <= 1'b0;
         wait_ack        <= 1'b0;
      end else begin
         approach_active <= (st_r == TAH_RAMP || st_r == TAH_RETR ||
                             st_r == TAH_STEP || st_r == TAH_SETTLE);   // RULE_04
         z_ramp_en       <= (st_r == TAH_RAMP) && !stop_cond && !z_at_max && !cmd_stop;
         z_ramp_loop     <= !apr_r.mode_ramp;   // RULE_02
         z_ramp_speed    <= apr_r.mode_ramp ? apr_r.speed : 8'h00;   // RULE_02
         crs_ext_mode    <= apr_r.single_z && (st_r == TAH_RAMP || st_r == TAH_RETR ||
                            st_r == TAH_STEP || st_r == TAH_SETTLE);   // RULE_09
         crs_gnd_mode    <= apr_r.gnd_apr && (st_r == TAH_RAMP);   // RULE_10
         wait_ack        <= (st_r == TAH_WACK) && !trig_out;   // RULE_23
      end
   end

endmodule

// [tb/tah_seq_sva.sv]
// Concurrent checks on the ports of the approach sequencer.
module tah_seq_sva
   import tah_pkg::*;
(
   input wire logic       sys_clk,
   input wire logic       rst_n,
   input wire logic       stop_cond,
   input wire logic       pos_reached,
   input wire logic       hreadyout,
   input wire logic       hresp,
   input wire logic       z_ramp_en,
   input wire logic       z_retract,
   input wire logic       fb_en,
   input wire logic       approach_active,
   input wire logic       crs_ser_valid,
   input wire logic [7:0] crs_ser_data,
   input wire logic       path_move,
   input wire logic       trig_out
);
   // ==========
   // Step decode and properties.
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   logic step;
   // A serial word that carries a coarse step.
   assign step = crs_ser_valid && crs_ser_data[7:4] == TAH_CMD_STEP;
   a_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus slave not ready or not okay");
   a_ramp_active: assert property (z_ramp_en |-> approach_active)
      else $error("ramp outside approach");
   a_ramp_retract: assert property (!(z_ramp_en && z_retract))
      else $error("ramp and retract together");
   a_step_no_ramp: assert property (step |-> !z_ramp_en)
      else $error("coarse step during ramp");
   a_step_fb_off: assert property (step |-> !fb_en)
      else $error("coarse step with feedback on");
   a_stop_ends: assert property (z_ramp_en && stop_cond |-> ##[1:3] !z_ramp_en)
      else $error("ramp not ended on stop");
   a_trig_at_point: assert property ($rose(trig_out) |-> pos_reached)
      else $error("trigger before point reached");
   a_move_pulse: assert property (path_move |=> !path_move)
      else $error("move pulse too long");
   a_ser_pulse: assert property (crs_ser_valid |=> !crs_ser_valid)
      else $error("serial valid too long");
   c_trig: cover property ($rose(trig_out));
   c_step: cover property (step);
   c_done: cover property ($fell(approach_active));
   c_fb: cover property ($rose(fb_en));
endmodule

bind tah_seq tah_seq_sva tah_seq_sva_inst (.sys_clk, .rst_n, .stop_cond, .pos_reached,
   .hreadyout, .hresp, .z_ramp_en, .z_retract, .fb_en, .approach_active, .crs_ser_valid,
   .crs_ser_data, .path_move, .trig_out);

// [tb/tah_partner.sv]
// Far side model: scanner limits, path stage, coarse controller and instrument.
module tah_partner
   import tah_pkg::*;
(
   input wire logic       sys_clk,
   input wire logic       z_ramp_en,
   input wire logic       z_retract,
   input wire logic       path_move,
   input wire logic       trig_out,
   input wire logic       crs_ser_valid,
   input wire logic [7:0] crs_ser_data,
   output logic           z_at_max,
   output logic           z_at_home,
   output logic           pos_reached,
   output logic           ack_in,
   output logic     [7:0] n_steps,
   output logic     [7:0] last_word,
   output logic     [7:0] n_trig
);
   logic [3:0] zpos_r;
   logic [2:0] move_r;
   logic [4:0] ack_r;
   logic       trig_r;
   // Start at home, no point pending, no acknowledge due.
   initial {zpos_r, move_r, ack_r, trig_r, n_steps, last_word, n_trig} = '0;
   // Far side behaviour.
   always @(posedge sys_clk) begin
      if (z_ramp_en && zpos_r != 4'hF) zpos_r <= zpos_r + 4'h1;
      else if (z_retract && zpos_r != 4'h0) zpos_r <= zpos_r - 4'h1;
      if (path_move) move_r <= 3'h5;
      else if (move_r != 3'h0) move_r <= move_r - 3'h1;
      trig_r <= trig_out;
      if (trig_r && !trig_out) begin
         ack_r  <= 5'h0E;
         n_trig <= n_trig + 8'h01;
      end else if (ack_r != 5'h00) ack_r <= ack_r - 5'h01;
      if (crs_ser_valid && crs_ser_data[7:4] == TAH_CMD_STEP) begin
         n_steps   <= n_steps + 8'h01;
         last_word <= crs_ser_data;
      end
   end
   // Acknowledge idles high and drops for three cycles after each trigger.
   assign ack_in      = ack_r == 5'h00 || ack_r > 5'h03;
   assign z_at_max    = zpos_r == 4'hF;
   assign z_at_home   = zpos_r == 4'h0;
   assign pos_reached = move_r == 3'h0;
endmodule

// [tb/tah_seq_tb.sv]
// Self-checking testbench of the approach and path handshake sequencer.
module tah_seq_tb
   import tah_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, stop_cond = 1'b0;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize  = 3'h2;
   logic [31:0] haddr  = 32'h0, hwdata = 32'h0, rdata, hrdata;
   logic hreadyout, hresp, z_at_max, z_at_home, pos_reached, ack_in, z_ramp_en, z_ramp_loop;
   logic z_retract, fb_en, approach_active, crs_gnd_mode, crs_ser_valid, path_move, wait_ack;
   logic trig_out;
   logic [7:0]  z_ramp_speed, crs_ser_data, n_steps, last_word, n_trig;
   int          bad_count = 0, comparisons = 0, cycles = 0;
   logic [7:0]  ofs [5]  = '{TAH_APR_OFS, TAH_CRS_OFS, TAH_PATH_OFS, TAH_HSK_OFS, TAH_TMO_OFS};
   logic [31:0] rstv [5] = '{TAH_APR_RST, TAH_CRS_RST, TAH_PATH_RST, TAH_HSK_RST, TAH_TMO_RST};

   tah_seq tah_seq_inst (.sys_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hreadyout, .hresp, .hrdata, .stop_cond, .z_at_max, .z_at_home,
      .pos_reached, .ack_in, .z_ramp_en, .z_ramp_loop, .z_ramp_speed, .z_retract, .fb_en,
      .approach_active, .crs_ext_mode(), .crs_gnd_mode, .aux_analog_out_2(), .aux_lv_level(),
      .crs_ser_valid, .crs_ser_data, .dedicated_cable_link(), .path_move, .path_point(),
      .trig_out, .wait_ack);
   tah_partner tah_partner_inst (.sys_clk, .z_ramp_en, .z_retract, .path_move, .trig_out,
      .crs_ser_valid, .crs_ser_data, .z_at_max, .z_at_home, .pos_reached, .ack_in, .n_steps,
      .last_word, .n_trig);

   // ==========
   // Clock, hang guard and shared tasks.
   initial forever #20 sys_clk = ~sys_clk;
   // Hang guard.
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 80000) begin
         bad_count++;
         report_and_stop;
      end
   end
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic xfer(input logic wr, input logic [7:0] adr, input logic [31:0] dat);
      @(posedge sys_clk);
      {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, wr, 24'h000000, adr};
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      {hsel, htrans, hwdata} <= {1'b0, 2'h0, dat};
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      rdata = hrdata;
   endtask
   task automatic wait_state(input tah_state_t st);
      do xfer(1'b0, TAH_STAT_OFS, 32'h0); while (rdata !== {21'h0, st});
   endtask
   task report_and_stop;
      $display("mismatches %0d comparisons %0d", bad_count, comparisons);
      if (bad_count == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   // ==========
   // Reset values, approach, coarse adjust, manual and external path.
   initial begin
      repeat (3) @(posedge sys_clk);
      rst_n <= 1'b1;
      foreach (ofs[i]) begin
         xfer(1'b0, ofs[i], 32'h0);
         chk("reset value", rdata, rstv[i]);
      end
      xfer(1'b0, 8'h40, 32'h0);
      chk("unmapped read", rdata, 32'h0);
      xfer(1'b1, TAH_CRS_OFS, 32'h0000_00C0);
      xfer(1'b1, TAH_APR_OFS, 32'h1002_0007);
      xfer(1'b1, TAH_CTRL_OFS, 32'h0000_0001);
      @(posedge sys_clk iff z_ramp_en === 1'b1);
      chk("started", approach_active, 1'b1);
      chk("ramp mode speed", {z_ramp_loop, z_ramp_speed}, 9'h010);
      @(posedge sys_clk iff n_steps == 8'h02);
      @(posedge sys_clk iff z_ramp_en === 1'b1);
      chk("ground in ramp", crs_gnd_mode, 1'b1);
      chk("step word", last_word, 8'h1C);
      stop_cond <= 1'b1;
      wait_state(TAH_IDLE);
      stop_cond <= 1'b0;
      chk("steps per cycle", n_steps, 8'h02);
      chk("target loop", {fb_en, approach_active}, 2'b10);
      xfer(1'b1, TAH_CTRL_OFS, 32'h0000_0004);
      wait_state(TAH_IDLE);
      chk("adjust fb on", {fb_en, n_steps}, 9'h103);
      xfer(1'b1, TAH_CTRL_OFS, 32'h0000_0080);
      xfer(1'b1, TAH_CTRL_OFS, 32'h0000_0004);
      wait_state(TAH_IDLE);
      chk("adjust fb off", {fb_en, n_steps}, 9'h004);
      xfer(1'b1, TAH_PATH_OFS, 32'h0001_0002);
      xfer(1'b1, TAH_CTRL_OFS, 32'h0000_0008);
      for (int i = 0; i < 2; i++) begin
         wait_state(TAH_MANUAL);
         xfer(1'b0, TAH_POINT_OFS, 32'h0);
         chk("point order", rdata, i);
         repeat (20) @(posedge sys_clk);
         xfer(1'b0, TAH_STAT_OFS, 32'h0);
         chk("held for proceed", rdata, {21'h0, TAH_MANUAL});
         xfer(1'b1, TAH_CTRL_OFS, 32'h0000_0010);
      end
      wait_state(TAH_IDLE);
      xfer(1'b1, TAH_HSK_OFS, 32'h0000_0102);
      xfer(1'b1, TAH_PATH_OFS, 32'h0002_0001);
      xfer(1'b1, TAH_CTRL_OFS, 32'h0000_0008);
      @(posedge sys_clk iff wait_ack === 1'b1);
      chk("pulse over", {trig_out, n_trig}, 9'h001);
      wait_state(TAH_IDLE);
      chk("ack released", wait_ack, 1'b0);
      chk("cycles per point", n_trig, 8'h02);
      report_and_stop;
   end
endmodule
